/* File: design/dsw_defines.svh */
// Notes on behaviour
// - One primary status word serves every reader; bus writes to it are ignored.
// - Primary bit 1 set when a run command has been received.
// - Primary bit 2 shows the emergency override mode is active.
// - Primary bit 5 set when the second ramp time pair is selected.
// - Primary bit 6 set in configuration state; the drive cannot be enabled then.
// - Primary bit 7 set while any alarm is present.
// - Primary bit 8 set while running per reference and command.
// - Primary bit 9 set when fully enabled and ready to turn the motor.
// - Primary bit 10 is direction: 1 forward, 0 reverse.
// - Primary bit 11 set while jog is active.
// - Primary bit 12 set under remote control, clear under local.
// - Primary bit 15 set while any fault is registered.
// - Speed feedback reads 8192 at a rated frequency below 8192 and 0 at zero speed.
// - Speed feedback is signed 16-bit, saturating, read-only.
// - Secondary bit 2 extended DC link, bit 10 DC link regulation.
// - Secondary bit 3 energy saving, bit 4 output frequency reduction.
// - Secondary bit 6 decelerating, bit 7 accelerating.
// - Secondary bit 8 set while the ramp is frozen.
// - Secondary bit 9 set once output frequency reached the reference.
// - Secondary bit 11 is 1 for 50 Hz defaults, 0 for 60 Hz.
// - Secondary bits 12, 13, 14: supply-dip ride, spinning catch, DC braking.
// - Secondary bit 15 set while output switching pulses are enabled.
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH
`define DSW_OFF_STATUS      4'h0
`define DSW_OFF_SPEED       4'h4
`define DSW_OFF_STATUS_TWO  4'h8
`define DSW_RESET_WORD      16'h0000
`define DSW_RATED_SCALE     5'h0d
`define DSW_SPEED_MAX       16'h7fff
`define DSW_SPEED_MIN       16'h8000
`define DSW_DIV_STEPS       5'h1d
`define DSW_P_RUN           1
`define DSW_P_FIRE          2
`define DSW_P_RAMP2         5
`define DSW_P_CONFIG        6
`define DSW_P_ALARM         7
`define DSW_P_RUNNING       8
`define DSW_P_ENABLED       9
`define DSW_P_FORWARD       10
`define DSW_P_JOG           11
`define DSW_P_REMOTE        12
`define DSW_P_UNDERVOLT     13
`define DSW_P_FAULT         15
`define DSW_S_DC_EXT        2
`define DSW_S_ENERGY        3
`define DSW_S_FREQ_RED      4
`define DSW_S_DECEL         6
`define DSW_S_ACCEL         7
`define DSW_S_FROZEN        8
`define DSW_S_SETPOINT      9
`define DSW_S_DC_REG        10
`define DSW_S_CFG_50HZ      11
`define DSW_S_RIDE          12
`define DSW_S_FLYING        13
`define DSW_S_DC_BRAKE      14
`define DSW_S_PWM           15
`endif

/* File: design/dsw_pkg.sv */
`default_nettype none
package dsw_pkg;
	typedef struct packed {
		logic run_cmd;
		logic fire_mode;
		logic ramp2_sel;
		logic config_state;
		logic alarm;
		logic running;
		logic enabled;
		logic forward;
		logic jog;
		logic remote;
		logic undervolt;
		logic fault;
	} dsw_prim_t;

	typedef struct packed {
		logic dc_ext;
		logic energy_save;
		logic freq_reduce;
		logic decel;
		logic accel;
		logic ramp_frozen;
		logic setpoint_ok;
		logic dc_reg;
		logic cfg_50hz;
		logic ride_through;
		logic flying_start;
		logic dc_brake;
		logic pwm_on;
	} dsw_sec_t;

	typedef enum logic [1:0] {
		DSW_IDLE,
		DSW_DIVIDE,
		DSW_STORE
	} dsw_div_state_t;
endpackage : dsw_pkg
`default_nettype wire

/* File: design/dsw_top.sv */
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`include "dsw_defines.svh"
`default_nettype none
module dsw_top
	import dsw_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	input  wire dsw_prim_t   prim_in,
	input  wire dsw_sec_t    sec_in,
	input  wire logic [15:0] motor_freq_in,
	input  wire logic [15:0] rated_freq_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic             enable_permit_out
);

	logic [15:0]    status_reg;
	logic [15:0]    status_two_reg;
	logic [15:0]    speed_reg;
	dsw_div_state_t div_state_reg;
	logic [28:0]    dividend_reg;
	logic [15:0]    divisor_reg;
	logic [16:0]    remain_reg;
	logic [28:0]    quot_reg;
	logic [4:0]     step_reg;
	logic           neg_reg;
	logic [16:0]    trial;
	logic           rd_take;

	function automatic logic [15:0] pack_primary(input dsw_prim_t p);
		logic [15:0] w;
		w = `DSW_RESET_WORD;
		w[`DSW_P_RUN] = p.run_cmd;
		w[`DSW_P_FIRE] = p.fire_mode;
		w[`DSW_P_RAMP2] = p.ramp2_sel;
		w[`DSW_P_CONFIG] = p.config_state;
		w[`DSW_P_ALARM] = p.alarm;
		w[`DSW_P_RUNNING] = p.running;
		w[`DSW_P_ENABLED] = p.enabled;
		w[`DSW_P_FORWARD] = p.forward;
		w[`DSW_P_JOG] = p.jog;
		w[`DSW_P_REMOTE] = p.remote;
		w[`DSW_P_UNDERVOLT] = p.undervolt;
		w[`DSW_P_FAULT] = p.fault;
		return w;
	endfunction : pack_primary

	function automatic logic [15:0] pack_secondary(input dsw_sec_t s);
		logic [15:0] w;
		w = `DSW_RESET_WORD;
		w[`DSW_S_DC_EXT] = s.dc_ext;
		w[`DSW_S_ENERGY] = s.energy_save;
		w[`DSW_S_FREQ_RED] = s.freq_reduce;
		w[`DSW_S_DECEL] = s.decel;
		w[`DSW_S_ACCEL] = s.accel;
		w[`DSW_S_FROZEN] = s.ramp_frozen;
		w[`DSW_S_SETPOINT] = s.setpoint_ok;
		w[`DSW_S_DC_REG] = s.dc_reg;
		w[`DSW_S_CFG_50HZ] = s.cfg_50hz;
		w[`DSW_S_RIDE] = s.ride_through;
		w[`DSW_S_FLYING] = s.flying_start;
		w[`DSW_S_DC_BRAKE] = s.dc_brake;
		w[`DSW_S_PWM] = s.pwm_on;
		return w;
	endfunction : pack_secondary

	function automatic logic [15:0] read_mux(input logic [3:0] off,
			input logic [15:0] st, input logic [15:0] sp,
			input logic [15:0] st2);
		logic [15:0] w;
		w = `DSW_RESET_WORD;
		if (off == `DSW_OFF_STATUS) begin
			w = st;
		end else if (off == `DSW_OFF_SPEED) begin
			w = sp;
		end else if (off == `DSW_OFF_STATUS_TWO) begin
			w = st2;
		end
		return w;
	endfunction : read_mux

	// Both words are rebuilt every cycle, so a reader sees state at most one cycle old.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status_reg <= `DSW_RESET_WORD;
		end else begin
			status_reg <= pack_primary(prim_in);
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status_two_reg <= `DSW_RESET_WORD;
		end else begin
			status_two_reg <= pack_secondary(sec_in);
		end
	end

	// Configuration state blocks enabling of the power stage.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			enable_permit_out <= 1'b0;
		end else begin
			enable_permit_out <= ~prim_in.config_state;
		end
	end

	// Speed scaling: low 13 bits of |f| * 8192 / rated by a restoring divider, one bit per cycle.
	// A serial divider costs 31 cycles of latency but avoids a wide combinational divide.
	assign trial = {remain_reg[15:0], dividend_reg[28]} - {1'b0, divisor_reg};

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_state_reg <= DSW_IDLE;
			dividend_reg <= 29'h0;
			divisor_reg <= 16'h0;
			remain_reg <= 17'h0;
			quot_reg <= 29'h0;
			step_reg <= 5'h0;
			neg_reg <= 1'b0;
		end else begin
			unique case (div_state_reg)
				DSW_IDLE: begin
					neg_reg <= motor_freq_in[15];
					dividend_reg <= {(motor_freq_in[15] ? 13'(16'h0 - motor_freq_in)
						: motor_freq_in[12:0]), 16'h0} >> (16 - `DSW_RATED_SCALE);
					divisor_reg <= rated_freq_in;
					remain_reg <= 17'h0;
					quot_reg <= 29'h0;
					step_reg <= 5'h0;
					div_state_reg <= DSW_DIVIDE;
				end
				DSW_DIVIDE: begin
					if (!trial[16]) begin
						remain_reg <= trial;
					end else begin
						remain_reg <= {remain_reg[15:0], dividend_reg[28]};
					end
					quot_reg <= {quot_reg[27:0], ~trial[16]};
					dividend_reg <= {dividend_reg[27:0], 1'b0};
					step_reg <= step_reg + 5'h1;
					if (step_reg == `DSW_DIV_STEPS - 5'h1) begin
						div_state_reg <= DSW_STORE;
					end
				end
				DSW_STORE: begin
					div_state_reg <= DSW_IDLE;
				end
				// The spare state code returns to idle, so the divider cannot lock up.
				default: begin
					div_state_reg <= DSW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			speed_reg <= `DSW_RESET_WORD;
		end else if (div_state_reg == DSW_STORE) begin
			if (divisor_reg == 16'h0 || quot_reg > 29'(`DSW_SPEED_MAX)) begin
				speed_reg <= neg_reg ? `DSW_SPEED_MIN : `DSW_SPEED_MAX;
			end else begin
				speed_reg <= neg_reg ? 16'h0 - quot_reg[15:0] : quot_reg[15:0];
			end
		end
	end

	// Bus slave: zero wait states, writes accepted and dropped.
	assign rd_take = hsel_in && htrans_in[1] && hready_in && !hwrite_in;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hrdata_out <= 32'h0;
		end else if (rd_take) begin
			hrdata_out <= {16'h0, read_mux(haddr_in[3:0], status_reg, speed_reg,
				status_two_reg)};
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	logic [31:0] hwdata_unused;
	assign hwdata_unused = hwdata_in;
	logic [2:0] hsize_unused;
	assign hsize_unused = hsize_in;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	property p_run;
		prim_in.run_cmd |=> status_reg[`DSW_P_RUN];
	endproperty
	a_run: assert property (p_run) else $error("run bit not set");

	property p_fire_fault;
		##1 (status_reg[`DSW_P_FIRE] == $past(prim_in.fire_mode))
			&& (status_reg[`DSW_P_FAULT] == $past(prim_in.fault));
	endproperty
	a_fire_fault: assert property (p_fire_fault) else $error("fire or fault bit wrong");

	property p_alarm_run;
		##1 (status_reg[`DSW_P_ALARM] == $past(prim_in.alarm))
			&& (status_reg[`DSW_P_RUNNING] == $past(prim_in.running))
			&& (status_reg[`DSW_P_ENABLED] == $past(prim_in.enabled));
	endproperty
	a_alarm_run: assert property (p_alarm_run) else $error("alarm/run/enable bit wrong");

	property p_config;
		prim_in.config_state |=> !enable_permit_out && status_reg[`DSW_P_CONFIG];
	endproperty
	a_config: assert property (p_config) else $error("config state not blocking");

	property p_dir_remote;
		##1 (status_reg[`DSW_P_FORWARD] == $past(prim_in.forward))
			&& (status_reg[`DSW_P_REMOTE] == $past(prim_in.remote))
			&& (status_reg[`DSW_P_JOG] == $past(prim_in.jog))
			&& (status_reg[`DSW_P_RAMP2] == $past(prim_in.ramp2_sel))
			&& (status_reg[`DSW_P_UNDERVOLT] == $past(prim_in.undervolt));
	endproperty
	a_dir_remote: assert property (p_dir_remote) else $error("mode bit wrong");

	property p_reserved;
		status_reg[0] == 1'b0 && status_reg[4:3] == 2'b00 && status_reg[14] == 1'b0
			&& status_two_reg[1:0] == 2'b00 && status_two_reg[5] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_ramp;
		##1 (status_two_reg[`DSW_S_DECEL] == $past(sec_in.decel))
			&& (status_two_reg[`DSW_S_ACCEL] == $past(sec_in.accel))
			&& (status_two_reg[`DSW_S_FROZEN] == $past(sec_in.ramp_frozen))
			&& (status_two_reg[`DSW_S_SETPOINT] == $past(sec_in.setpoint_ok));
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp bit wrong");

	property p_dc;
		##1 (status_two_reg[`DSW_S_DC_EXT] == $past(sec_in.dc_ext))
			&& (status_two_reg[`DSW_S_DC_REG] == $past(sec_in.dc_reg))
			&& (status_two_reg[`DSW_S_ENERGY] == $past(sec_in.energy_save))
			&& (status_two_reg[`DSW_S_FREQ_RED] == $past(sec_in.freq_reduce));
	endproperty
	a_dc: assert property (p_dc) else $error("dc or energy bit wrong");

	property p_misc;
		##1 (status_two_reg[`DSW_S_CFG_50HZ] == $past(sec_in.cfg_50hz))
			&& (status_two_reg[`DSW_S_RIDE] == $past(sec_in.ride_through))
			&& (status_two_reg[`DSW_S_FLYING] == $past(sec_in.flying_start))
			&& (status_two_reg[`DSW_S_DC_BRAKE] == $past(sec_in.dc_brake))
			&& (status_two_reg[`DSW_S_PWM] == $past(sec_in.pwm_on));
	endproperty
	a_misc: assert property (p_misc) else $error("function bit wrong");

	property p_rated;
		(div_state_reg == DSW_IDLE && motor_freq_in == rated_freq_in
			&& rated_freq_in != 16'h0 && rated_freq_in < 16'h1000)
			|-> ##31 speed_reg == 16'h2000;
	endproperty
	a_rated: assert property (p_rated) else $error("rated speed not 8192");

	property p_zero;
		(div_state_reg == DSW_IDLE && motor_freq_in == 16'h0 && rated_freq_in != 16'h0)
			|-> ##31 speed_reg == 16'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("zero speed not 0");

	property p_read;
		(rd_take && haddr_in[3:0] == `DSW_OFF_STATUS)
			|=> hrdata_out == {16'h0, $past(status_reg)};
	endproperty
	a_read: assert property (p_read) else $error("status read wrong");

	property p_okay;
		hreadyout_out && !hresp_out;
	endproperty
	a_okay: assert property (p_okay) else $error("bus not ready or error");

	// A write must leave the read data alone, since every word here is read-only.
	property p_wr_ignored;
		(hsel_in && htrans_in[1] && hready_in && hwrite_in) |=> $stable(hrdata_out);
	endproperty
	a_wr_ignored: assert property (p_wr_ignored) else $error("write changed data");

	property p_read_speed;
		(rd_take && haddr_in[3:0] == `DSW_OFF_SPEED)
			|=> hrdata_out == {16'h0, $past(speed_reg)};
	endproperty
	a_read_speed: assert property (p_read_speed) else $error("speed read wrong");

	property p_read_two;
		(rd_take && haddr_in[3:0] == `DSW_OFF_STATUS_TWO)
			|=> hrdata_out == {16'h0, $past(status_two_reg)};
	endproperty
	a_read_two: assert property (p_read_two) else $error("second status read wrong");

	property p_read_spare;
		(rd_take && haddr_in[3:0] != `DSW_OFF_STATUS && haddr_in[3:0] != `DSW_OFF_SPEED
			&& haddr_in[3:0] != `DSW_OFF_STATUS_TWO) |=> hrdata_out == 32'h0;
	endproperty
	a_read_spare: assert property (p_read_spare) else $error("spare offset not zero");

	property p_run_clear;
		!prim_in.run_cmd |=> !status_reg[`DSW_P_RUN];
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("run bit not clear");

	property p_permit;
		!prim_in.config_state |=> enable_permit_out;
	endproperty
	a_permit: assert property (p_permit) else $error("enable permit missing");

	// The sign follows the input unless the magnitude rounds down to zero.
	property p_sign;
		div_state_reg == DSW_STORE
			|=> (speed_reg[15] == $past(neg_reg)) || speed_reg == 16'h0;
	endproperty
	a_sign: assert property (p_sign) else $error("speed sign wrong");

	// A fresh result lands every 31 cycles; readers may rely on that refresh rate.
	property p_div_len;
		div_state_reg == DSW_IDLE
			|-> ##30 div_state_reg == DSW_STORE ##1 div_state_reg == DSW_IDLE;
	endproperty
	a_div_len: assert property (p_div_len) else $error("divider period wrong");

	c_read_two: cover property (rd_take && haddr_in[3:0] == `DSW_OFF_STATUS_TWO);
	c_write: cover property (hsel_in && htrans_in[1] && hwrite_in);
	c_sat: cover property (div_state_reg == DSW_STORE && quot_reg > 29'h7fff);
	c_fault: cover property (status_reg[`DSW_P_FAULT]);
	c_neg: cover property (div_state_reg == DSW_STORE && neg_reg);

endmodule : dsw_top
`default_nettype wire

/* File: testbench/drive_status_words_tb_top.sv */
`default_nettype none
module drive_status_words_tb_top
	import dsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        permit;
	dsw_prim_t   prim_in = '0;
	dsw_sec_t    sec_in = '0;
	logic [15:0] motor_freq_in = 16'h0000;
	logic [15:0] rated_freq_in = 16'h03e8;
	logic [31:0] exp_q[$];
	int          mismatches = 0;
	int          check_count = 0;

	always #50 ref_clk_in = ~ref_clk_in;

	dsw_top i_dsw_top (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
		.hwdata_in(hwdata), .prim_in(prim_in), .sec_in(sec_in),
		.motor_freq_in(motor_freq_in), .rated_freq_in(rated_freq_in),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.enable_permit_out(permit));

	dsw_reader_model i_dsw_reader_model (
		.clk_in(ref_clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
		.haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
		.hwdata_out(hwdata));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		if (mismatches == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	function automatic logic [15:0] prim_word(input dsw_prim_t p);
		prim_word = {p.fault, 1'b0, p.undervolt, p.remote, p.jog, p.forward, p.enabled,
			p.running, p.alarm, p.config_state, p.ramp2_sel, 2'h0, p.fire_mode, p.run_cmd, 1'b0};
	endfunction : prim_word

	function automatic logic [15:0] sec_word(input dsw_sec_t s);
		sec_word = {s.pwm_on, s.dc_brake, s.flying_start, s.ride_through, s.cfg_50hz,
			s.dc_reg, s.setpoint_ok, s.ramp_frozen, s.accel, s.decel, 1'b0, s.freq_reduce,
			s.energy_save, s.dc_ext, 2'h0};
	endfunction : sec_word

	// Magnitude is scaled and floored first, then signed, then clipped to the 16-bit range.
	function automatic logic [15:0] speed_word(input logic [15:0] f, input logic [15:0] r);
		int fi;
		int q;
		fi = $signed(f);
		q = ((fi < 0) ? -fi : fi) * 8192 / int'(r);
		if (fi < 0) begin
			speed_word = (q > 32768) ? 16'h8000 : 16'(-q);
		end else begin
			speed_word = (q > 32767) ? 16'h7fff : 16'(q);
		end
	endfunction : speed_word

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		i_dsw_reader_model.xfer(a, 1'b0, 32'h0);
	endtask : rd

	task automatic run_case(input logic [15:0] f, input logic [15:0] r);
		dsw_prim_t   p;
		dsw_sec_t    s;
		logic [31:0] w;
		{p, s} = 25'($urandom);
		w = $urandom;
		@(posedge ref_clk_in);
		prim_in <= p;
		sec_in <= s;
		motor_freq_in <= f;
		rated_freq_in <= r;
		// Two divider periods guarantee a result taken from the new inputs.
		repeat (64) @(posedge ref_clk_in);
		check({31'h0, permit}, {31'h0, ~p.config_state});
		rd(32'h0, {16'h0, prim_word(p)});
		rd(32'h4, {16'h0, speed_word(f, r)});
		rd(32'h8, {16'h0, sec_word(s)});
		rd(32'hc, 32'h0);
		i_dsw_reader_model.xfer(32'h0, 1'b1, w);
		i_dsw_reader_model.xfer(32'h4, 1'b1, w);
		rd(32'h0, {16'h0, prim_word(p)});
		rd(32'h4, {16'h0, speed_word(f, r)});
		check({31'h0, hresp}, 32'h0);
	endtask : run_case

	initial begin
		forever begin
			@(i_dsw_reader_model.got);
			check(i_dsw_reader_model.got_data, exp_q.pop_front());
		end
	end

	initial begin
		#3_000_000;
		mismatches++;
		summarize();
	end

	initial begin
		logic [15:0] mag;
		void'($urandom(18008));
		repeat (12) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(32'h0, 32'h0);
		rd(32'h8, 32'h0);
		run_case(16'h03e8, 16'h03e8);
		run_case(16'h0000, 16'h03e8);
		run_case(16'hfc18, 16'h03e8);
		run_case(16'h1388, 16'h03e8);
		run_case(16'hec78, 16'h03e8);
		run_case(16'h1000, 16'h0400);
		run_case(16'hf000, 16'h0400);
		run_case(16'h1fff, 16'h1fff);
		repeat (20) begin
			mag = 16'($urandom_range(8191, 0));
			run_case($urandom_range(1, 0) ? -mag : mag, 16'($urandom_range(65535, 1)));
		end
		summarize();
	end
endmodule : drive_status_words_tb_top
`default_nettype wire

/* File: testbench/dsw_reader_model.sv */
`default_nettype none
// A command source that reads the status words over the register bus.
// It waits on hready with no fixed count; only the bench watchdog ends a stuck wait.
module dsw_reader_model (
	input  wire logic        clk_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hrdata_in,
	output logic             hsel_out,
	output logic [31:0]      haddr_out,
	output logic [1:0]       htrans_out,
	output logic             hwrite_out,
	output logic [2:0]       hsize_out,
	output logic [31:0]      hwdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] got_data;
	event        got;

	initial begin
		hsel_out = 1'b0;
		haddr_out = 32'h0;
		htrans_out = 2'h0;
		hwrite_out = 1'b0;
		hsize_out = 3'h2;
		hwdata_out = 32'h0;
	end

	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_in);
		hsel_out <= 1'b1;
		htrans_out <= 2'h2;
		haddr_out <= a;
		hwrite_out <= w;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		hsel_out <= 1'b0;
		htrans_out <= 2'h0;
		hwdata_out <= d;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		// Write data is inverted once the phase ends, so a stale value never looks valid.
		hwdata_out <= ~d;
		got_data = hrdata_in;
		if (!w) begin
			-> got;
		end
	endtask : xfer
endmodule : dsw_reader_model
`default_nettype wire
